// ===== hdl/ums_regs_map.svh
// Purpose: register offsets, bit positions and reset values of the
//          modem status, scratch and divisor register slice
// Assumes: 3-bit register offsets of a classic serial channel
// Notes:   definitions only
`ifndef UMS_REGS_MAP_SVH
`define UMS_REGS_MAP_SVH

// register offsets
`define UMS_OFF_DIV_LO      3'h0
`define UMS_OFF_DIV_HI      3'h1
`define UMS_OFF_LINE_CTL    3'h3
`define UMS_OFF_MODEM_CTL   3'h4
`define UMS_OFF_MODEM_ST    3'h6
`define UMS_OFF_SCRATCH     3'h7

// line control fields
`define UMS_LINE_DIV_ACCESS 7

// modem control fields
`define UMS_MCTL_DTR        0
`define UMS_MCTL_RTS        1
`define UMS_MCTL_RING       2
`define UMS_MCTL_CARRIER    3
`define UMS_MCTL_LOOP       4
`define UMS_MCTL_MASK       8'h1F

// interrupt enable fields
`define UMS_IEN_MODEM       3
`define UMS_IEN_MASK        8'h0F

// modem status fields
`define UMS_MST_D_CTS       0
`define UMS_MST_D_DSR       1
`define UMS_MST_D_RING      2
`define UMS_MST_D_CARRIER   3
`define UMS_MST_CTS         4
`define UMS_MST_DSR         5
`define UMS_MST_RING        6
`define UMS_MST_CARRIER     7

// reset values and divisor constants
`define UMS_RST_BYTE        8'h00
`define UMS_RST_DIV         16'h0000
`define UMS_RST_NIB         4'h0
`define UMS_DIV_ONE         16'h0001
`define UMS_DIV_ZERO        16'h0000

`endif

// ===== hdl/ums_pkg.sv
// Purpose: shared types of the modem status and divisor register slice
// Assumes: register offsets come from ums_regs_map.svh
// Notes:   types only
package ums_pkg;

	// one register access from the host register port
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ums_req_t;

	// active-low modem input pins
	typedef struct packed {
		logic cts_in_n;
		logic dsr_in_n;
		logic ring_indicator_in_n;
		logic carrier_detect_in_n;
	} ums_modem_in_t;

endpackage : ums_pkg

// ===== hdl/ums_baud_gen.sv
// Purpose: baud rate generator counting down the 16-bit divisor
// Assumes: divisor of zero stops the generator
// Notes:   a nonzero divisor is loaded only at reload, so a new one applies
//          from the next baud period; a zero divisor stops the count at once
`include "ums_regs_map.svh"

module ums_baud_gen #(
	parameter int DIV_W = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_ce,
	input  wire logic [DIV_W-1:0] i_divisor,
	output logic                  o_tick
);

	logic [DIV_W-1:0] cnt_ff;
	logic             tick_ff;

	// countdown, reload from the live divisor at each period end
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt_ff  <= `UMS_RST_DIV;
			tick_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			tick_ff <= 1'b0;
			if (i_divisor == `UMS_DIV_ZERO)
				cnt_ff <= `UMS_RST_DIV; // stopped
			else if (cnt_ff <= `UMS_DIV_ONE)
			begin
				cnt_ff  <= i_divisor;
				tick_ff <= (cnt_ff == `UMS_DIV_ONE);
			end
			else
				cnt_ff <= cnt_ff - `UMS_DIV_ONE;
		end
	end

	assign o_tick = tick_ff;

endmodule : ums_baud_gen

// ===== hdl/ums_regs.sv
// Purpose: modem status, scratch and baud divisor registers of one
//          serial channel, with the line and modem control bits they need
// Assumes: register port and modem pins synchronous to i_clk
// Notes:   read data appears one cycle after the read strobe; a read of
//          modem status clears its change flags
`include "ums_regs_map.svh"

module ums_regs (
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_ce,
	input  wire ums_pkg::ums_req_t     i_req,
	input  wire ums_pkg::ums_modem_in_t i_modem,
	output logic [7:0]                 o_rdata,
	output logic                       o_rvalid,
	output logic [15:0]                o_divisor,
	output logic                       o_baud_tick,
	output logic                       o_modem_irq,
	output logic                       o_dtr_out_n,
	output logic                       o_rts_out_n,
	output logic                       o_loopback
);
	import ums_pkg::*;

	logic [7:0]  scratch_byte_ff;
	logic [7:0]  baud_divisor_low_ff;
	logic [7:0]  baud_divisor_high_ff;
	logic [7:0]  line_control_reg_ff;
	logic [7:0]  modem_control_reg_ff;
	logic [7:0]  interrupt_enable_reg_ff;
	logic [3:0]  delta_ff;
	logic [3:0]  prev_lvl_ff;
	logic        primed_ff;
	logic [7:0]  rdata_ff;
	logic        rvalid_ff;
	logic        irq_ff;
	logic        dtr_n_ff;
	logic        rts_n_ff;
	logic [15:0] divisor_ff;
	logic        tick_w;
	logic [3:0]  lvl;
	logic [3:0]  nxt_delta;
	logic [7:0]  modem_line_status;
	logic        div_sel;
	logic        loop;
	logic        wr_ok;
	logic        rd_status;
	logic        loop_ff;

	assign div_sel   = line_control_reg_ff[`UMS_LINE_DIV_ACCESS];
	assign loop      = modem_control_reg_ff[`UMS_MCTL_LOOP];
	assign wr_ok     = i_ce && i_req.wr;
	assign rd_status = i_ce && i_req.rd
		&& (i_req.addr == `UMS_OFF_MODEM_ST);

	// levels of clear-to-send, data-set-ready, ring, carrier: bits 4..7
	always_comb
	begin
		if (loop)
		begin
			lvl[0] = modem_control_reg_ff[`UMS_MCTL_RTS];
			lvl[1] = modem_control_reg_ff[`UMS_MCTL_DTR];
			lvl[2] = modem_control_reg_ff[`UMS_MCTL_RING];
			lvl[3] = modem_control_reg_ff[`UMS_MCTL_CARRIER];
		end
		else
		begin
			lvl[0] = ~i_modem.cts_in_n;
			lvl[1] = ~i_modem.dsr_in_n;
			lvl[2] = ~i_modem.ring_indicator_in_n;
			lvl[3] = ~i_modem.carrier_detect_in_n;
		end
	end

	assign modem_line_status = {lvl, delta_ff};

	// change flags; ring flag only on end of ringing, set beats read-clear
	always_comb
	begin
		nxt_delta = rd_status ? `UMS_RST_NIB : delta_ff;
		if (primed_ff)
		begin
			nxt_delta[`UMS_MST_D_CTS] = nxt_delta[`UMS_MST_D_CTS]
				| (lvl[0] ^ prev_lvl_ff[0]);
			nxt_delta[`UMS_MST_D_DSR] = nxt_delta[`UMS_MST_D_DSR]
				| (lvl[1] ^ prev_lvl_ff[1]);
			nxt_delta[`UMS_MST_D_RING] = nxt_delta[`UMS_MST_D_RING]
				| (prev_lvl_ff[2] & ~lvl[2]);
			nxt_delta[`UMS_MST_D_CARRIER] = nxt_delta[`UMS_MST_D_CARRIER]
				| (lvl[3] ^ prev_lvl_ff[3]);
		end
	end

	// change tracking; first cycle after reset only learns the levels
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			delta_ff    <= `UMS_RST_NIB;
			prev_lvl_ff <= `UMS_RST_NIB;
			primed_ff   <= 1'b0;
		end
		else if (i_ce)
		begin
			delta_ff    <= nxt_delta;
			prev_lvl_ff <= lvl;
			primed_ff   <= 1'b1;
		end
	end

	// modem status interrupt, level while any flag set and enabled
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			irq_ff <= 1'b0;
		else if (i_ce)
			irq_ff <= (|nxt_delta)
				&& interrupt_enable_reg_ff[`UMS_IEN_MODEM];
	end

	// scratch byte: storage only, nothing else reads it
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			scratch_byte_ff <= `UMS_RST_BYTE;
		else if (wr_ok && i_req.addr == `UMS_OFF_SCRATCH)
			scratch_byte_ff <= i_req.wdata;
	end

	// divisor bytes, reachable only with divisor access set
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			baud_divisor_low_ff  <= `UMS_RST_BYTE;
			baud_divisor_high_ff <= `UMS_RST_BYTE;
		end
		else if (wr_ok && div_sel)
		begin
			if (i_req.addr == `UMS_OFF_DIV_LO)
				baud_divisor_low_ff <= i_req.wdata;
			if (i_req.addr == `UMS_OFF_DIV_HI)
				baud_divisor_high_ff <= i_req.wdata;
		end
	end

	// control registers; interrupt enable sits under the high divisor byte
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			line_control_reg_ff     <= `UMS_RST_BYTE;
			modem_control_reg_ff    <= `UMS_RST_BYTE;
			interrupt_enable_reg_ff <= `UMS_RST_BYTE;
		end
		else if (wr_ok)
		begin
			if (i_req.addr == `UMS_OFF_LINE_CTL)
				line_control_reg_ff <= i_req.wdata;
			if (i_req.addr == `UMS_OFF_MODEM_CTL)
				modem_control_reg_ff <= i_req.wdata & `UMS_MCTL_MASK;
			if (i_req.addr == `UMS_OFF_DIV_HI && !div_sel)
				interrupt_enable_reg_ff <= i_req.wdata & `UMS_IEN_MASK;
		end
	end

	// registered outputs toward the line and generator
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			divisor_ff <= `UMS_RST_DIV;
			dtr_n_ff   <= 1'b1;
			rts_n_ff   <= 1'b1;
			loop_ff    <= 1'b0;
		end
		else if (i_ce)
		begin
			divisor_ff <= {baud_divisor_high_ff, baud_divisor_low_ff};
			// pins held inactive in loopback, the peer must not see them
			dtr_n_ff <= loop | ~modem_control_reg_ff[`UMS_MCTL_DTR];
			rts_n_ff <= loop | ~modem_control_reg_ff[`UMS_MCTL_RTS];
			// flag moves with the pins, so no cycle shows both active
			loop_ff  <= loop;
		end
	end

	// read mux, one cycle latency; receive data lives outside this slice
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			rdata_ff  <= `UMS_RST_BYTE;
			rvalid_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			rvalid_ff <= i_req.rd;
			if (i_req.rd)
			begin
				case (i_req.addr)
				`UMS_OFF_DIV_LO:
					rdata_ff <= div_sel ? baud_divisor_low_ff
						: `UMS_RST_BYTE;
				`UMS_OFF_DIV_HI:
					rdata_ff <= div_sel ? baud_divisor_high_ff
						: interrupt_enable_reg_ff;
				`UMS_OFF_LINE_CTL:  rdata_ff <= line_control_reg_ff;
				`UMS_OFF_MODEM_CTL: rdata_ff <= modem_control_reg_ff;
				`UMS_OFF_MODEM_ST:  rdata_ff <= modem_line_status;
				`UMS_OFF_SCRATCH:   rdata_ff <= scratch_byte_ff;
				default:            rdata_ff <= `UMS_RST_BYTE;
				endcase
			end
		end
	end

	// nonzero divisor applied at the next reload of the generator; zero stops it at once
	ums_baud_gen #(
		.DIV_W (16)
	) u_baud (
		.i_clk     (i_clk),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.i_divisor (divisor_ff),
		.o_tick    (tick_w)
	);

	// tick re-registered so the output comes from a flop here
	logic tick_ff;
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
			tick_ff <= 1'b0;
		else if (i_ce)
			tick_ff <= tick_w;
	end

	assign o_rdata     = rdata_ff;
	assign o_rvalid    = rvalid_ff;
	assign o_divisor   = divisor_ff;
	assign o_baud_tick = tick_ff;
	assign o_modem_irq = irq_ff;
	assign o_dtr_out_n = dtr_n_ff;
	assign o_rts_out_n = rts_n_ff;
	assign o_loopback  = loop_ff;

endmodule : ums_regs

// ===== sim/ums_regs_props.sv
// Purpose: port checks of the modem status and divisor slice
// Assumes: one clock, sync active-high reset, offsets of the map
// Notes:   internal registers are unseen, so checks tie ports together
`include "ums_regs_map.svh"

module ums_regs_props
	import ums_pkg::*;
(
	input wire logic          i_clk,
	input wire logic          i_rst,
	input wire logic          i_ce,
	input wire ums_req_t      i_req,
	input wire ums_modem_in_t i_modem,
	input wire logic [7:0]    o_rdata,
	input wire logic          o_rvalid,
	input wire logic [15:0]   o_divisor,
	input wire logic          o_baud_tick,
	input wire logic          o_modem_irq,
	input wire logic          o_dtr_out_n,
	input wire logic          o_rts_out_n,
	input wire logic          o_loopback
);
	logic [3:0] pin_st;
	logic       rd_ok;

	// status nibble as the pins alone would give it
	assign pin_st = ~{i_modem.carrier_detect_in_n, i_modem.ring_indicator_in_n,
		i_modem.dsr_in_n, i_modem.cts_in_n};
	assign rd_ok = i_ce && i_req.rd;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);

	rd_answer_a: assert property (rd_ok |=> o_rvalid)
		else $error("read not answered");
	no_answer_a: assert property (i_ce && !i_req.rd |=> !o_rvalid)
		else $error("answer without a read");
	rdata_hold_a: assert property (!o_rvalid |-> $stable(o_rdata))
		else $error("read data moved without a read");
	pin_status_a: assert property (
		rd_ok && i_req.addr == `UMS_OFF_MODEM_ST && !o_loopback && !i_req.wr
		&& $stable(i_modem) && !$past(i_rst) && $past(i_ce)
		|=> o_rdata[7:4] == $past(pin_st))
		else $error("status nibble not the inverted pins");
	loop_quiet_a: assert property (o_loopback |-> o_dtr_out_n && o_rts_out_n)
		else $error("control outputs driven in loopback");
	irq_hold_a: assert property (
		o_modem_irq && i_ce && !i_req.wr
		&& !(i_req.rd && i_req.addr == `UMS_OFF_MODEM_ST) |=> o_modem_irq)
		else $error("modem irq dropped without a status read");
	div_stable_a: assert property (
		!(i_ce && i_req.wr) [*2] |=> $stable(o_divisor))
		else $error("divisor moved without a write");
	zero_stop_a: assert property ((o_divisor == 16'h0000) [*4] |-> !o_baud_tick)
		else $error("tick with zero divisor");
	tick_gap_a: assert property (
		o_baud_tick && i_ce && o_divisor > 16'h0001 |=> !o_baud_tick)
		else $error("ticks too close for the divisor");
endmodule : ums_regs_props

bind ums_regs ums_regs_props u_props (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req),
	.i_modem(i_modem), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
	.o_divisor(o_divisor), .o_baud_tick(o_baud_tick),
	.o_modem_irq(o_modem_irq), .o_dtr_out_n(o_dtr_out_n),
	.o_rts_out_n(o_rts_out_n), .o_loopback(o_loopback)
);

// ===== sim/ums_modem_peer.sv
// Purpose: modem peer driving the active-low handshake lines
// Assumes: levels change just after a clock edge
// Notes:   lines idle inactive (high) until commanded
module ums_modem_peer
	import ums_pkg::*;
(
	input  wire logic    i_clk,
	input  wire logic [3:0] i_level,
	output ums_modem_in_t o_pins
);
	timeunit 1ns;
	timeprecision 1ns;

	// registered so a new level lands one edge after the command
	always @(posedge i_clk)
		o_pins <= i_level;
endmodule : ums_modem_peer

// ===== sim/tb_top.sv
// Purpose: self-checking bench of the modem status and divisor slice
// Assumes: offsets of ums_regs_map.svh
// Notes:   random stimulus from a fixed xorshift seed
`include "ums_regs_map.svh"

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ums_pkg::*;

	logic i_clk, i_rst, i_ce, tick, irq, dtr_n, rts_n, loopb, rvalid;
	ums_req_t      req;
	ums_modem_in_t modem;
	logic [3:0]    pin_set;
	logic [7:0]    rdata, d, lo, hi;
	logic [15:0]   divisor;
	logic [31:0]   seed, v;
	int            num_errors, check_count, g;

	ums_modem_peer u_peer (.i_clk(i_clk), .i_level(pin_set), .o_pins(modem));
	ums_regs u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_req(req),
		.i_modem(modem), .o_rdata(rdata), .o_rvalid(rvalid),
		.o_divisor(divisor), .o_baud_tick(tick), .o_modem_irq(irq),
		.o_dtr_out_n(dtr_n), .o_rts_out_n(rts_n), .o_loopback(loopb));

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs

	// pins {cts,dsr,ri,cd} to status {cd,ri,dsr,cts}, inverted
	function automatic logic [3:0] pin_exp(input logic [3:0] n);
		return ~{n[0], n[1], n[2], n[3]};
	endfunction : pin_exp

	function automatic logic [3:0] loop_exp(input logic [3:0] m);
		return {m[3], m[2], m[0], m[1]};
	endfunction : loop_exp

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wreg(input logic [2:0] a, input logic [7:0] w);
		@(posedge i_clk);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: w};
		@(posedge i_clk);
		req.wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [2:0] a, output logic [7:0] r);
		@(posedge i_clk);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		req.rd <= 1'b0;
		#1;
		chk(rvalid, 1'b1);
		r = rdata;
	endtask : rreg

	// counts the cycles from one tick to the next
	task automatic tgap(output int n);
		int k;
		k = 0;
		n = 1;
		while (k < 2 && n < 5000)
		begin
			@(posedge i_clk);
			#1;
			if (tick === 1'b1)
				k++;
			else if (k == 1)
				n++;
		end
	endtask : tgap

	task automatic conclude();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// hang guard sized well above the longest baud wait
	initial
	begin
		repeat (20000) @(posedge i_clk);
		num_errors++;
		conclude();
	end

	initial
	begin
		i_rst = 1'b1;
		i_ce = 1'b1;
		req = '0;
		pin_set = 4'hF;
		seed = 32'h21e64236;
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		rreg(`UMS_OFF_SCRATCH, d);
		chk(d, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			v = (i == 0) ? 32'hFF : xs();
			wreg(`UMS_OFF_SCRATCH, v[7:0]);
			rreg(`UMS_OFF_SCRATCH, d);
			chk(d, v[7:0]);
		end
		// a write with the clock enable low must not land
		@(posedge i_clk);
		i_ce <= 1'b0;
		wreg(`UMS_OFF_SCRATCH, ~v[7:0]);
		i_ce <= 1'b1;
		rreg(`UMS_OFF_SCRATCH, d);
		chk(d, v[7:0]);
		v = xs();
		lo = v[7:0] | 8'h02;
		hi = v[15:8] & 8'h03;
		wreg(`UMS_OFF_LINE_CTL, 8'h80);
		wreg(`UMS_OFF_DIV_LO, lo);
		wreg(`UMS_OFF_DIV_HI, hi);
		rreg(`UMS_OFF_DIV_LO, d);
		chk(d, lo);
		rreg(`UMS_OFF_DIV_HI, d);
		chk(d, hi);
		chk(divisor, {hi, lo});
		wreg(`UMS_OFF_LINE_CTL, 8'h00);
		rreg(`UMS_OFF_DIV_LO, d);
		chk(d, 8'h00);
		rreg(`UMS_OFF_DIV_HI, d);
		chk(d, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			v = xs();
			@(posedge i_clk);
			pin_set <= (i == 0) ? 4'h0 : v[3:0];
			repeat (3) @(posedge i_clk);
			rreg(`UMS_OFF_MODEM_ST, d);
			chk(d[7:4], pin_exp(pin_set));
		end
		// drive both control pins, then enter loopback with them still set
		wreg(`UMS_OFF_MODEM_CTL, 8'h03);
		rreg(`UMS_OFF_MODEM_ST, d);
		chk({loopb, dtr_n, rts_n}, 3'b000);
		for (int m = 0; m < 16; m++)
		begin
			wreg(`UMS_OFF_MODEM_CTL, 8'h10 | 8'(m ^ 3));
			rreg(`UMS_OFF_MODEM_ST, d);
			chk(d[7:4], loop_exp(4'(m ^ 3)));
			chk({loopb, dtr_n, rts_n}, 3'b111);
		end
		// offset 1 is the interrupt enable while divisor access is off
		wreg(`UMS_OFF_MODEM_CTL, 8'h00);
		wreg(`UMS_OFF_DIV_HI, 8'h08);
		@(posedge i_clk);
		pin_set <= 4'hF;
		repeat (3) @(posedge i_clk);
		rreg(`UMS_OFF_MODEM_ST, d);
		@(posedge i_clk);
		pin_set <= 4'h7;
		repeat (3) @(posedge i_clk);
		#1;
		chk(irq, 1'b1);
		rreg(`UMS_OFF_MODEM_ST, d);
		chk(d, 8'h11);
		rreg(`UMS_OFF_MODEM_ST, d);
		chk(d, 8'h10);
		chk(irq, 1'b0);
		// ringing starts: no flag; ringing ends: ring flag
		@(posedge i_clk);
		pin_set <= 4'h5;
		repeat (3) @(posedge i_clk);
		rreg(`UMS_OFF_MODEM_ST, d);
		chk(d, 8'h50);
		chk(irq, 1'b0);
		@(posedge i_clk);
		pin_set <= 4'h7;
		repeat (3) @(posedge i_clk);
		rreg(`UMS_OFF_MODEM_ST, d);
		chk(d, 8'h14);
		wreg(`UMS_OFF_LINE_CTL, 8'h80);
		wreg(`UMS_OFF_DIV_HI, 8'h00);
		wreg(`UMS_OFF_DIV_LO, 8'h03);
		tgap(g);
		tgap(g);
		chk(g >= 3 && g <= 4, 1'b1);
		wreg(`UMS_OFF_DIV_LO, 8'h05);
		tgap(g);
		tgap(g);
		chk(g >= 5 && g <= 6, 1'b1);
		conclude();
	end
endmodule : tb_top
